// >>> rtl/ttig_pkg.sv
// Package: constants for the trace identifier generator and checker
package ttig_pkg;
  localparam int                TTIG_BYTES      = 16;
  localparam int                TTIG_ACCESS_POINT_IDENT_BYTES = 15;
  localparam int                TTIG_IDX_W      = 4;
  localparam int                TTIG_HDR_POS    = 0;
  localparam logic [7:0]        TTIG_HDR_MARK   = 8'h80;
  localparam logic [7:0]        TTIG_ACCESS_POINT_IDENT_MASK  = 8'h7F;
  localparam logic [6:0]        TTIG_CRC_POLY   = 7'h09;
  localparam logic [6:0]        TTIG_CRC_INIT   = 7'h00;
  localparam logic [7:0]        TTIG_BYTE_RST   = 8'h00;
  localparam logic [3:0]        TTIG_IDX_LAST   = 4'hF;
  localparam logic [3:0]        TTIG_IDX_FIRST  = 4'h0;
  localparam logic [2:0]        TTIG_CRC_STEPS  = 3'h7;

  typedef enum logic [1:0] {TTIG_IDLE, TTIG_CALC, TTIG_RUN} ttig_state_type;

  // One CRC-7 step over one bit, first bit taken as highest order
  function automatic logic [6:0] ttig_crc_bit(input logic [6:0] crc, input logic b);
    logic fb;
    fb = crc[6] ^ b;
    ttig_crc_bit = {crc[5:0], 1'b0} ^ (fb ? TTIG_CRC_POLY : TTIG_CRC_INIT);
  endfunction

  // CRC-7 over one byte, bit 1 (MSB) first
  function automatic logic [6:0] ttig_crc_byte(input logic [6:0] crc, input logic [7:0] d);
    logic [6:0] c;
    c = crc;
    for (int k = 7; k >= 0; k--) begin
      c = ttig_crc_bit(c, d[k]);
    end
    ttig_crc_byte = c;
  endfunction
endpackage

// >>> rtl/ttig_skid.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module ttig_skid
  import ttig_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_valid,
  output logic            o_ready,
  input  wire logic [7:0] i_data,
  output logic            o_valid,
  input  wire logic       i_ready,
  output logic [7:0]      o_data
);
  logic [7:0] mem_q [2];
  logic       wp_q;
  logic       rp_q;
  logic [1:0] cnt_q;
  wire        push = i_valid && o_ready;
  wire        pop  = o_valid && i_ready;

  assign o_ready = (cnt_q != 2'h2);
  assign o_valid = (cnt_q != 2'h0);
  assign o_data  = mem_q[rp_q];

  // Storage and pointers
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mem_q[0] <= TTIG_BYTE_RST;
      mem_q[1] <= TTIG_BYTE_RST;
      wp_q     <= 1'b0;
      rp_q     <= 1'b0;
      cnt_q    <= 2'h0;
    end else begin
      if (push) begin
        mem_q[wp_q] <= i_data;
        wp_q        <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

// >>> rtl/ttig_cmp.sv
// Sink comparator: accepted trace against expected trace
`timescale 1ns/100ps
`default_nettype none
module ttig_cmp
  import ttig_pkg::*;
(
  input  wire logic                     i_clk,
  input  wire logic                     i_arst_n,
  input  wire logic [TTIG_BYTES*8-1:0]  i_accepted,
  input  wire logic [TTIG_BYTES*8-1:0]  i_expected,
  input  wire logic                     i_legacy,
  output logic                          o_mismatch
);
  logic [TTIG_BYTES-1:0] diff;
  logic                  same_byte;

  // Per-byte differences
  genvar g;
  generate
    for (g = 0; g < TTIG_BYTES; g++) begin : g_cmp
      assign diff[g] = i_accepted[g*8 +: 8] != i_expected[g*8 +: 8];
    end
  endgenerate

  // Legacy: a repeated single byte is what a peer without identifier sends
  assign same_byte = (i_accepted == {TTIG_BYTES{i_accepted[7:0]}});

  // Mismatch flag, registered
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_mismatch <= 1'b0;
    end else begin
      o_mismatch <= i_legacy ? !same_byte : |diff;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/ttig_top.sv
// Trace identifier generator and checker, top level
//
// Behaviour
// - Source sends the trace identifier bytes without pause, identifier plus header.
// - Trace is sixteen bytes: one header byte, fifteen identifier bytes.
// - Header MSB is one, low seven bits hold the CRC-7.
// - Every identifier byte has its MSB forced to zero.
// - CRC-7 is remainder of string times x^7 over x^7+x^3+1.
// - Bit one of byte zero is the highest-order coefficient.
// - Check bit one is remainder MSB, check bit seven its LSB.
// - CRC computed once after each load and stored, not per send.
// - Sink compares accepted trace with expected trace.
// - Management writes transmitted and expected, reads accepted sixteen bytes.
// - Mismatch result flags misconnection and gates delivery of traffic.
// - Legacy mode: no expected trace, received trace is one repeated byte.
`timescale 1ns/100ps
`default_nettype none
module ttig_top
  import ttig_pkg::*;
(
  input  wire logic                    I_CLK,
  input  wire logic                    I_ARST_N,
  input  wire logic                    I_TX_WR,
  input  wire logic [3:0]              I_TX_ADDR,
  input  wire logic [7:0]              I_TX_DATA,
  input  wire logic                    I_EXP_WR,
  input  wire logic [3:0]              I_EXP_ADDR,
  input  wire logic [7:0]              I_EXP_DATA,
  input  wire logic                    I_LEGACY,
  input  wire logic                    I_RX_VALID,
  input  wire logic                    I_RX_START,
  input  wire logic [7:0]              I_RX_DATA,
  input  wire logic                    I_RD_ADDR_VALID,
  input  wire logic [3:0]              I_RD_ADDR,
  input  wire logic                    I_OUT_READY,
  output logic                         O_OUT_VALID,
  output logic [7:0]                   O_OUT_DATA,
  output logic                         O_OUT_START,
  output logic [7:0]                   O_RD_DATA,
  output logic                         O_MISMATCH,
  output logic                         O_DELIVER_EN
);
  logic [7:0]            tx_q  [TTIG_BYTES];
  logic [7:0]            exp_q [TTIG_BYTES];
  logic [7:0]            acc_q [TTIG_BYTES];
  logic [6:0]            crc_q;
  logic [3:0]            calc_idx_q;
  logic [3:0]            send_idx_q;
  logic [3:0]            rx_idx_q;
  logic                  rx_any_q;
  ttig_state_type        state_q;
  logic [7:0]            send_byte;
  logic                  buf_ready;
  logic                  buf_valid;
  logic [7:0]            buf_data;
  logic                  out_valid_q;
  logic [7:0]            out_data_q;
  logic                  out_start_q;
  logic [7:0]            rd_data_q;
  logic                  mismatch;
  logic                  deliver_q;
  logic [TTIG_BYTES*8-1:0] acc_flat;
  logic [TTIG_BYTES*8-1:0] exp_flat;
  logic [7:0]            calc_byte;
  logic                  out_take;

  // Flatten arrays for the comparator
  genvar g;
  generate
    for (g = 0; g < TTIG_BYTES; g++) begin : g_flat
      assign acc_flat[g*8 +: 8] = acc_q[g];
      assign exp_flat[g*8 +: 8] = exp_q[g];
    end
  endgenerate

  // Byte fed to the CRC: header byte carries zeroed check bits
  assign calc_byte = (calc_idx_q == TTIG_IDX_FIRST) ? TTIG_HDR_MARK
                   : (tx_q[calc_idx_q] & TTIG_ACCESS_POINT_IDENT_MASK);

  // Byte to transmit at the current position
  assign send_byte = (send_idx_q == TTIG_IDX_FIRST) ? (TTIG_HDR_MARK | {1'b0, crc_q})
                   : (tx_q[send_idx_q] & TTIG_ACCESS_POINT_IDENT_MASK);

  assign out_take = !out_valid_q || I_OUT_READY;

  // Management writes of transmitted and expected strings
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      for (int i = 0; i < TTIG_BYTES; i++) begin
        tx_q[i]  <= TTIG_BYTE_RST;
        exp_q[i] <= TTIG_BYTE_RST;
      end
    end else begin
      if (I_TX_WR) begin
        tx_q[I_TX_ADDR] <= I_TX_DATA;
      end
      if (I_EXP_WR) begin
        exp_q[I_EXP_ADDR] <= I_EXP_DATA;
      end
    end
  end

  // CRC precompute after each load, then continuous send
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state_q    <= TTIG_IDLE;
      crc_q      <= TTIG_CRC_INIT;
      calc_idx_q <= TTIG_IDX_FIRST;
      send_idx_q <= TTIG_IDX_FIRST;
    end else begin
      case (state_q)
        TTIG_IDLE: begin
          crc_q      <= TTIG_CRC_INIT;
          calc_idx_q <= TTIG_IDX_FIRST;
          state_q    <= TTIG_CALC;
        end
        TTIG_CALC: begin
          crc_q      <= ttig_crc_byte(crc_q, calc_byte);
          calc_idx_q <= calc_idx_q + 4'h1;
          if (calc_idx_q == TTIG_IDX_LAST) begin
            state_q <= TTIG_RUN;
          end
        end
        TTIG_RUN: begin
          if (buf_ready) begin
            send_idx_q <= send_idx_q + 4'h1;
          end
        end
        default: begin
          state_q <= TTIG_IDLE;
        end
      endcase
      if (I_TX_WR) begin
        state_q <= TTIG_IDLE;
      end
    end
  end

  // Two-entry buffer on the outgoing byte stream
  ttig_skid u_skid (
    .i_clk    (I_CLK),
    .i_arst_n (I_ARST_N),
    .i_valid  (state_q == TTIG_RUN),
    .o_ready  (buf_ready),
    .i_data   (send_byte),
    .o_valid  (buf_valid),
    .i_ready  (out_take),
    .o_data   (buf_data)
  );

  // Registered output stage; start marks the header byte
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      out_valid_q <= 1'b0;
      out_data_q  <= TTIG_BYTE_RST;
      out_start_q <= 1'b0;
    end else if (out_take) begin
      out_valid_q <= buf_valid;
      out_data_q  <= buf_data;
      out_start_q <= buf_valid && buf_data[7];
    end
  end

  // Capture the received string into the accepted trace
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rx_idx_q <= TTIG_IDX_FIRST;
      rx_any_q <= 1'b0;
      for (int i = 0; i < TTIG_BYTES; i++) begin
        acc_q[i] <= TTIG_BYTE_RST;
      end
    end else if (I_RX_VALID) begin
      if (I_RX_START || I_LEGACY) begin
        acc_q[I_LEGACY ? rx_idx_q : TTIG_IDX_FIRST] <= I_RX_DATA;
        rx_idx_q <= I_LEGACY ? rx_idx_q + 4'h1 : 4'h1;
      end else begin
        acc_q[rx_idx_q] <= I_RX_DATA;
        rx_idx_q        <= rx_idx_q + 4'h1;
      end
      rx_any_q <= 1'b1;
    end
  end

  // Sink comparison
  ttig_cmp u_cmp (
    .i_clk      (I_CLK),
    .i_arst_n   (I_ARST_N),
    .i_accepted (acc_flat),
    .i_expected (exp_flat),
    .i_legacy   (I_LEGACY),
    .o_mismatch (mismatch)
  );

  // Read port for the accepted trace and delivery gate
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rd_data_q <= TTIG_BYTE_RST;
      deliver_q <= 1'b0;
    end else begin
      if (I_RD_ADDR_VALID) begin
        rd_data_q <= acc_q[I_RD_ADDR];
      end
      deliver_q <= rx_any_q && !mismatch;
    end
  end

  assign O_OUT_VALID  = out_valid_q;
  assign O_OUT_DATA   = out_data_q;
  assign O_OUT_START  = out_start_q;
  assign O_RD_DATA    = rd_data_q;
  assign O_MISMATCH   = mismatch;
  assign O_DELIVER_EN = deliver_q;

  // Header byte always has MSB set and carries the stored CRC
  hdr_mark_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (state_q == TTIG_RUN && send_idx_q == TTIG_IDX_FIRST)
      |-> (send_byte == {1'b1, crc_q}))
    else $error("header byte wrong");

  // Identifier bytes never carry MSB
  access_point_ident_msb_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (O_OUT_VALID && !O_OUT_START) |-> !O_OUT_DATA[7])
    else $error("identifier byte MSB set");

  // Sending position advances on accept
  send_adv_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (state_q == TTIG_RUN && buf_ready && !I_TX_WR) |=> (send_idx_q == $past(send_idx_q) + 4'h1))
    else $error("send position stalled");

  // CRC phase is still running on its eighth cycle
  crc_len_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    ($rose(state_q == TTIG_CALC) && !I_TX_WR)[*1] ##0 (!I_TX_WR)[*8]
      |-> (state_q == TTIG_CALC))
    else $error("crc phase ended early");

  // Mismatch follows a differing expected string
  mism_set_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (!I_LEGACY && acc_flat != exp_flat) |=> $past(I_LEGACY) || O_MISMATCH)
    else $error("mismatch not raised");

  // Mismatch clears on equality
  mism_clr_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (!I_LEGACY && acc_flat == exp_flat) |=> !O_MISMATCH)
    else $error("mismatch not cleared");

  // Delivery is blocked while mismatched
  gate_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    O_MISMATCH |=> !O_DELIVER_EN)
    else $error("delivery not gated");

  // Read returns the accepted byte one cycle later
  rd_port_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (I_RD_ADDR_VALID && !I_RX_VALID) |=> (O_RD_DATA == acc_q[$past(I_RD_ADDR)]))
    else $error("read data wrong");

  // Start marker only on a header byte
  start_hdr_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    O_OUT_START |-> (O_OUT_VALID && O_OUT_DATA[7]))
    else $error("start without header");

  // Every valid byte with its MSB set is flagged as start
  hdr_start_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (O_OUT_VALID && O_OUT_DATA[7]) |-> O_OUT_START)
    else $error("header without start");

  // Check phase opens at byte zero with a cleared remainder
  crc_open_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    $rose(state_q == TTIG_CALC)
      |-> (calc_idx_q == TTIG_IDX_FIRST && crc_q == TTIG_CRC_INIT))
    else $error("crc phase start wrong");

  // Check phase ends after its sixteenth byte
  crc_end_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (state_q == TTIG_CALC && calc_idx_q == TTIG_IDX_LAST && !I_TX_WR)
      |=> (state_q == TTIG_RUN))
    else $error("crc phase did not end");

  // A write to the transmitted string restarts the check phase
  tx_restart_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    I_TX_WR |=> (state_q == TTIG_IDLE))
    else $error("load did not restart");

  // Once running, the stream keeps a byte on offer
  stream_on_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (state_q == TTIG_RUN)[*3] |-> O_OUT_VALID)
    else $error("stream interrupted");

  // A stalled byte stands until the receiver takes it
  out_hold_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (O_OUT_VALID && !I_OUT_READY)
      |=> (O_OUT_VALID && $stable(O_OUT_DATA) && $stable(O_OUT_START)))
    else $error("stalled byte changed");

  // Start byte of a received trace lands at byte zero
  rx_start_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (I_RX_VALID && I_RX_START && !I_LEGACY)
      |=> (acc_q[TTIG_HDR_POS] == $past(I_RX_DATA) && rx_idx_q == 4'h1))
    else $error("received start misplaced");

  // Legacy bytes fill the accepted trace round robin
  rx_legacy_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (I_RX_VALID && I_LEGACY) |=> (rx_idx_q == $past(rx_idx_q) + 4'h1))
    else $error("legacy index stalled");

  // Delivery opens once a trace has arrived and matches
  deliver_on_a: assert property (@(posedge I_CLK) disable iff (!I_ARST_N)
    (rx_any_q && !O_MISMATCH) |=> O_DELIVER_EN)
    else $error("delivery not opened");
endmodule
`default_nettype wire

// >>> testbench/ttig_far_end.sv
// Far-end trail termination: takes the outgoing stream and sends a received trace
`timescale 1ns/100ps
`default_nettype none
module ttig_far_end (
  input  wire logic       i_clk,
  input  wire logic       i_stall,
  input  wire logic       i_valid,
  input  wire logic       i_start,
  input  wire logic [7:0] i_data,
  output logic            o_ready,
  output logic            o_rx_valid,
  output logic            o_rx_start,
  output logic [7:0]      o_rx_data
);
  logic [8:0] got_q [$];

  // Idle receive lines at time zero
  initial begin
    o_ready = 1'b0;
    o_rx_valid = 1'b0;
    o_rx_start = 1'b0;
    o_rx_data = 8'h00;
  end

  // Random stalls while stalling is enabled, so the buffer must hold bytes
  always @(negedge i_clk) begin
    o_ready <= !(i_stall && ($urandom_range(3) == 0));
  end

  // Capture each accepted byte with its start flag
  always @(posedge i_clk) begin
    if (i_valid && o_ready) begin
      got_q.push_back({i_start, i_data});
    end
  end

  // Sends sixteen bytes, byte 0 first and flagged as start
  task automatic send(input logic [127:0] s);
    for (int i = 0; i < 16; i++) begin
      @(negedge i_clk);
      o_rx_valid = 1'b1;
      o_rx_start = (i == 0);
      o_rx_data = s[127-8*i -: 8];
    end
    @(negedge i_clk);
    o_rx_valid = 1'b0;
    o_rx_start = 1'b0;
    o_rx_data = ~o_rx_data;  // Released line shows no stale byte
  endtask
endmodule
`default_nettype wire

// >>> testbench/ttig_tb_top.sv
// Testbench for the trace identifier generator and checker
`timescale 1ns/100ps
`default_nettype none
module ttig_tb_top;
  import ttig_pkg::*;
  logic         clk, arst_n, tx_wr, exp_wr, legacy, rd_v, stall, rdy, out_v, out_s, mism, dlv;
  logic [3:0]   tx_a, exp_a, rd_a;
  logic [7:0]   tx_d, exp_d, rd_d, out_d, rx_d, b;
  logic         rx_v, rx_s;
  logic [7:0]   txs [16];
  logic [127:0] str;
  logic [8:0]   q [$];
  int           error_cnt = 0;
  int           tests_run = 0;
  int           n, k;

  ttig_top u_ttig_top (
    .I_CLK(clk), .I_ARST_N(arst_n), .I_TX_WR(tx_wr), .I_TX_ADDR(tx_a), .I_TX_DATA(tx_d),
    .I_EXP_WR(exp_wr), .I_EXP_ADDR(exp_a), .I_EXP_DATA(exp_d), .I_LEGACY(legacy),
    .I_RX_VALID(rx_v), .I_RX_START(rx_s), .I_RX_DATA(rx_d), .I_RD_ADDR_VALID(rd_v),
    .I_RD_ADDR(rd_a), .I_OUT_READY(rdy), .O_OUT_VALID(out_v), .O_OUT_DATA(out_d),
    .O_OUT_START(out_s), .O_RD_DATA(rd_d), .O_MISMATCH(mism), .O_DELIVER_EN(dlv)
  );

  ttig_far_end u_ttig_far_end (
    .i_clk(clk), .i_stall(stall), .i_valid(out_v), .i_start(out_s), .i_data(out_d),
    .o_ready(rdy), .o_rx_valid(rx_v), .o_rx_start(rx_s), .o_rx_data(rx_d)
  );

  // Free-running clock, 10 ns period
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic report_and_stop;
    if (error_cnt == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask

  task automatic cyc(input int c);
    repeat (c) @(negedge clk);
  endtask

  // Reference CRC-7 with integers: header 0x80, masked bytes, first bit highest
  function automatic int ref_crc();
    int c = 0;
    int d;
    for (int i = 0; i < 16; i++) begin
      d = (i == 0) ? 128 : (txs[i] & 127);
      for (int j = 7; j >= 0; j--) begin
        c = ((c << 1) & 127) ^ ((((c >> 6) ^ (d >> j)) & 1) ? 9 : 0);
      end
    end
    return c;
  endfunction

  // Receives a trace and checks both flags after the settle time
  task automatic rx_chk(input logic [127:0] s, input logic m);
    u_ttig_far_end.send(s);
    cyc(4);
    chk_flag(mism, m);
    chk_flag(dlv, !m);
  endtask

  initial begin
    {arst_n, tx_wr, exp_wr, legacy, rd_v, stall, tx_a, exp_a, rd_a, tx_d, exp_d} = '0;
    n = $urandom(32'h0ce5);
    cyc(2);
    chk_flag(out_v, 1'b0);
    chk_flag(mism, 1'b0);
    arst_n = 1'b1;
    // Source stream, two rounds of random identifiers with receiver stalls
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < 16; i++) begin
        @(negedge clk);
        tx_wr = 1'b1;
        tx_a = i[3:0];
        tx_d = 8'($urandom);
        txs[i] = tx_d;
      end
      @(negedge clk);
      tx_wr = 1'b0;
      stall = 1'b1;
      cyc(40);
      u_ttig_far_end.got_q.delete();
      n = 0;
      while (u_ttig_far_end.got_q.size() < 48 && n < 500) begin
        cyc(1);
        n++;
      end
      if (n == 500) begin
        error_cnt++;
        report_and_stop();
      end
      q = u_ttig_far_end.got_q;
      for (int i = 0; i < 15 && q[0][8] !== 1'b1; i++) void'(q.pop_front());
      for (int i = 0; i < 32; i++) begin
        k = (i % 16 == 0) ? (128 | ref_crc()) : (txs[i % 16] & 127);
        chk_byte(q[i][7:0], k[7:0]);
        chk_flag(q[i][8], i % 16 == 0);
      end
    end
    // Expected trace provisioned, then match, corruption and restore
    str = {$urandom, $urandom, $urandom, $urandom};
    for (int i = 0; i < 16; i++) begin
      @(negedge clk);
      exp_wr = 1'b1;
      exp_a = i[3:0];
      exp_d = str[127-8*i -: 8];
    end
    @(negedge clk);
    exp_wr = 1'b0;
    rx_chk(str, 1'b0);
    for (int i = 0; i < 16; i++) begin
      @(negedge clk);
      rd_v = 1'b1;
      rd_a = i[3:0];
      @(negedge clk);
      rd_v = 1'b0;
      cyc(1);
      chk_byte(rd_d, str[127-8*i -: 8]);
    end
    k = $urandom_range(15);
    rx_chk(str ^ (128'h1 << (8 * (15 - k))), 1'b1);
    rx_chk(str, 1'b0);
    // Legacy peer: one repeated byte, then a stray byte
    legacy = 1'b1;
    b = 8'($urandom);
    rx_chk({16{b}}, 1'b0);
    rx_chk({{15{b}}, ~b}, 1'b1);
    report_and_stop();
  end
endmodule
`default_nettype wire
